// >>> rtl/wdog_pkg.sv
package wdog_pkg;

  // Clock rate of the single core clock
  localparam int unsigned CLK_HZ = 10_000_000;

  // Time-out interval, figures in milliseconds
  localparam int unsigned TIMEOUT_MIN_MS = 1100;
  localparam int unsigned TIMEOUT_TYP_MS = 1600;
  localparam int unsigned TIMEOUT_MAX_MS = 2300;

  // Typical interval in cycles; least time rounded up
  localparam longint unsigned TIMEOUT_TYP_CYC =
    (64'(TIMEOUT_TYP_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000;
  localparam longint unsigned TIMEOUT_MIN_CYC =
    (64'(TIMEOUT_MIN_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000;

  // Kick period on the controller side, well under the minimum time-out
  localparam int unsigned KICK_PERIOD_MS = 300;
  localparam longint unsigned KICK_PERIOD_CYC =
    64'(KICK_PERIOD_MS) * 64'(CLK_HZ) / 64'd1000;

  // Length of the time-out low pulse in cycles
  localparam int unsigned TIMEOUT_PULSE_CYC = 1;

  // Counter width wide enough for the longest count used
  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

endpackage

// >>> rtl/wdog_link_if.sv
`timescale 1ns/100ps
// Kick line between controller and watchdog, plus reset wiring
interface wdog_link_if;
  logic kick_o;              // Controller drive value
  logic kick_oe;             // Controller drives the kick line
  logic watchdog_kick_input; // Resolved level seen by the watchdog
  logic watchdog_timeout_out_n;
  logic master_reset_in_n;   // Resolved master reset level

  // Floating kick line is held at its last level; no edge appears
  modport watchdog
  (
    input  watchdog_kick_input,
    output watchdog_timeout_out_n,
    input  master_reset_in_n
  );

  modport controller
  (
    output kick_o,
    output kick_oe,
    input  watchdog_timeout_out_n
  );
endinterface

// >>> rtl/module_supervisor_watchdog.sv
`timescale 1ns/100ps
// The kick pin and the master reset pin come from outside the clock
// domain, so each passes two flops before any logic reads it. The two
// straps stand for assembly links and are static, so they are read
// directly.
// A kick edge at the pin clears the timer three cycles later. A kick
// that lands in the last two cycles of an interval therefore cannot
// stop that time-out. Controllers must kick well inside the minimum
// interval, and the kicker end does so by construction.
// The interval uses the typical figure. A build that must meet the
// minimum and maximum should set TIMEOUT_CYC from its real clock.
// The time-out pulse lasts PULSE_CYC cycles. In the alternate assembly
// the same cycles also pull the combined module reset low.
module module_supervisor_watchdog
  import wdog_pkg::*;
#(
  parameter longint unsigned TIMEOUT_CYC = TIMEOUT_TYP_CYC,
  parameter int unsigned     PULSE_CYC   = TIMEOUT_PULSE_CYC
)
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic enable_link_fitted,
  input  wire logic reset_route_fitted,
  wdog_link_if.watchdog link,
  output logic      timeout_pulse_n,
  output logic      module_reset_n,
  output logic      watchdog_running
);

  initial
  begin
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (64'd1 << CNT_W))
      $error("TIMEOUT_CYC out of range");
    if (PULSE_CYC < 1 || PULSE_CYC >= TIMEOUT_CYC)
      $error("PULSE_CYC out of range");
    // Counters need at least two bits to tell start from last value
    if (CNT_W < 2)
      $error("CNT_W too narrow");
  end

  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Counter helpers
  // One adder shape for both counters; no wrap can happen because
  // the timer is cleared at its last value and the pulse counter holds there
  function automatic logic [CNT_W-1:0] cnt_next
  (
    input logic [CNT_W-1:0] cnt
  );
    return cnt + CNT_ONE;
  endfunction

  // Terminal count test shared by the timer and the pulse stretcher
  function automatic logic cnt_done
  (
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] last
  );
    return cnt == last;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  // All state of the watchdog end lives in one packed record
  typedef struct packed {
    // Kick pin synchroniser and edge memory
    logic             kick_s1;
    logic             kick_s2;
    logic             kick_prev;
    logic             primed;
    // Interval timer
    logic             running;
    logic [CNT_W-1:0] cnt;
    // Time-out pulse stretcher
    logic             pulse_act;
    logic [CNT_W-1:0] pulse_cnt;
    // Registered outputs
    logic             wdo_n;
    logic             rst_out_n;
    // Master reset pin synchroniser
    logic             mr_s1;
    logic             mr_s2;
  } state_s;

  // Reset image: outputs idle high and the timer stopped; each
  // synchroniser starts at the idle level of its pin
  localparam state_s RESET_STATE = '{
    kick_s1:   1'b0,
    kick_s2:   1'b0,
    kick_prev: 1'b0,
    primed:    1'b0,
    running:   1'b0,
    cnt:       CNT_ZERO,
    pulse_act: 1'b0,
    pulse_cnt: CNT_ZERO,
    wdo_n:     1'b1,
    rst_out_n: 1'b1,
    mr_s1:     1'b1,
    mr_s2:     1'b1
  };

  state_s s_q;
  state_s s_d;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic edge_seen;
    edge_seen = 1'b0;
    s_d = s_q;
    // Two flops before any logic reads the pin levels
    s_d.kick_s1 = link.watchdog_kick_input;
    s_d.kick_s2 = s_q.kick_s1;
    s_d.kick_prev = s_q.kick_s2;
    // Master reset pin takes the same two-flop path
    s_d.mr_s1 = link.master_reset_in_n;
    s_d.mr_s2 = s_q.mr_s1;
    // First sample only primes the edge detector; a high pin level at start
    // still reads as one kick edge
    s_d.primed = 1'b1;
    edge_seen = s_q.primed && (s_q.kick_s2 != s_q.kick_prev);
    // Without the enable link no edge ever starts the timer
    if (!enable_link_fitted)
    begin
      s_d.running = 1'b0;
      s_d.cnt = CNT_ZERO;
    end
    else if (edge_seen)
    begin
      s_d.running = 1'b1;
      s_d.cnt = CNT_ZERO;
    end
    // A kick in the same cycle as the last count wins, so no pulse
    // is raised for an interval that was just restarted
    else if (s_q.running)
    begin
      // Last count: raise the pulse and start the next interval at once
      if (cnt_done(s_q.cnt, LAST_CNT))
      begin
        s_d.cnt = CNT_ZERO;
        s_d.pulse_act = 1'b1;
        s_d.pulse_cnt = CNT_ZERO;
      end
      else
      begin
        s_d.cnt = cnt_next(s_q.cnt);
      end
    end
    // Hold time-out low for the pulse length, then release
    if (s_q.pulse_act)
    begin
      if (cnt_done(s_q.pulse_cnt, PULSE_LAST))
        s_d.pulse_act = 1'b0;
      else
        s_d.pulse_cnt = cnt_next(s_q.pulse_cnt);
    end
    // Pulling the enable link also cancels a pulse already in flight
    if (!enable_link_fitted)
      s_d.pulse_act = 1'b0;
    // Outputs take the next pulse state so they leave flops directly
    s_d.wdo_n = !s_d.pulse_act;
    // Alternate assembly: time-out merged into master reset
    s_d.rst_out_n = s_q.mr_s2 &&
                    !(reset_route_fitted && s_d.pulse_act);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= RESET_STATE;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  // Time-out line towards the controller end
  assign link.watchdog_timeout_out_n = s_q.wdo_n;
  // Same pulse for logic outside the link
  assign timeout_pulse_n = s_q.wdo_n;
  // Combined module reset, master reset merged with time-out
  assign module_reset_n = s_q.rst_out_n;
  // Timer armed by a first kick edge
  assign watchdog_running = s_q.running;

endmodule

// >>> rtl/watchdog_kicker.sv
`timescale 1ns/100ps
// Controller end: floats the kick line until enabled, then toggles it
module watchdog_kicker
  import wdog_pkg::*;
#(
  parameter longint unsigned KICK_CYC = KICK_PERIOD_CYC
)
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic kick_enable,
  wdog_link_if.controller link,
  output logic      kicking
);

  initial
  begin
    if (KICK_CYC < 1 || KICK_CYC >= TIMEOUT_MIN_CYC)
      $error("KICK_CYC must be below the minimum time-out");
  end

  localparam logic [CNT_W-1:0] KICK_LAST = CNT_W'(KICK_CYC - 1);

  typedef struct packed {
    logic             level;
    logic             drive;
    logic [CNT_W-1:0] cnt;
  } state_s;

  state_s s_q;
  state_s s_d;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_d = s_q;
    if (!kick_enable)
    begin
      // Released line: no edges, so a running watchdog is no longer kicked and times out
      s_d.drive = 1'b0;
      s_d.cnt = CNT_ZERO;
    end
    else if (!s_q.drive)
    begin
      // Start driving with the held level already toggled, so the first edge comes at once
      s_d.drive = 1'b1;
      s_d.level = !s_q.level;
      s_d.cnt = CNT_ZERO;
    end
    else if (s_q.cnt == KICK_LAST)
    begin
      s_d.level = !s_q.level;
      s_d.cnt = CNT_ZERO;
    end
    else
      s_d.cnt = s_q.cnt + CNT_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{level: 1'b0, drive: 1'b0, cnt: CNT_ZERO};
    else
      s_q <= s_d;
  end

  assign link.kick_o = s_q.level;
  assign link.kick_oe = s_q.drive;
  assign kicking = s_q.drive;

endmodule

// >>> test/wdog_link_monitor.sv
`timescale 1ns/100ps
module wdog_link_monitor
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic kick_o,
  input wire logic kick_oe,
  input wire logic watchdog_kick_input,
  input wire logic watchdog_timeout_out_n,
  input wire logic master_reset_in_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] quiet_q;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since last kick edge or time-out; saturates so it never wraps
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      quiet_q <= 8'h00;
    else if ($changed(watchdog_kick_input) || !watchdog_timeout_out_n)
      quiet_q <= 8'h00;
    else if (quiet_q != 8'hFF)
      quiet_q <= quiet_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_timeout_spacing_ok: assert property (
    $fell(watchdog_timeout_out_n) |-> quiet_q >= 8'h12 && quiet_q <= 8'h1A)
    else $error("time-out spacing wrong");
  a_kick_defers_timeout: assert property (
    quiet_q >= 8'h04 && quiet_q < 8'h12 |-> watchdog_timeout_out_n)
    else $error("time-out too soon after kick");
  a_timeout_pulse_one: assert property (
    $fell(watchdog_timeout_out_n) |=> watchdog_timeout_out_n)
    else $error("time-out pulse too long");
  a_first_kick_edge: assert property (
    $rose(kick_oe) |-> ##[0:2] $changed(kick_o))
    else $error("no edge after drive starts");
  a_kick_not_early: assert property (
    kick_oe && $changed(kick_o) |=> $stable(kick_o) [*4])
    else $error("kick toggled too soon");
  a_kick_not_late: assert property (
    kick_oe && $changed(kick_o) |-> ##[1:6] ($changed(kick_o) || !kick_oe))
    else $error("kick toggled too late");
  // Main scenarios reached
  c_timeout: cover property ($fell(watchdog_timeout_out_n));
  c_drive: cover property ($rose(kick_oe));
  c_master: cover property ($fell(master_reset_in_n));
endmodule

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
  import wdog_pkg::*;
  localparam int unsigned TO = 20;
  logic core_clk = 1'b0;
  logic rst_n    = 1'b0;
  logic en_fit   = 1'b1;
  logic route    = 1'b1;
  logic kick_en  = 1'b0;
  logic mr_n     = 1'b1;
  logic held     = 1'b0;
  logic tmo_n, mod_rst_n, running, kicking;
  int   mismatches = 0, comparisons = 0, ntmo = 0, nrst = 0, len, seed;
  wdog_link_if link ();
  assign link.watchdog_kick_input = held;
  assign link.master_reset_in_n   = mr_n;
  // Released line keeps its last level, so a release makes no edge
  always @(link.kick_oe or link.kick_o)
    if (link.kick_oe === 1'b1) held = link.kick_o;
  always #50 core_clk = ~core_clk;
  // Tally low cycles of the time-out and combined reset outputs
  always @(posedge core_clk)
  begin
    ntmo += (tmo_n === 1'b0);
    nrst += (mod_rst_n === 1'b0);
  end
  module_supervisor_watchdog #(.TIMEOUT_CYC(TO), .PULSE_CYC(1))
    u_module_supervisor_watchdog (.core_clk(core_clk), .rst_n(rst_n),
    .enable_link_fitted(en_fit), .reset_route_fitted(route), .link(link),
    .timeout_pulse_n(tmo_n), .module_reset_n(mod_rst_n),
    .watchdog_running(running));
  watchdog_kicker #(.KICK_CYC(5)) u_watchdog_kicker (.core_clk(core_clk),
    .rst_n(rst_n), .kick_enable(kick_en), .link(link), .kicking(kicking));
  wdog_link_monitor u_wdog_link_monitor (.core_clk(core_clk), .rst_n(rst_n),
    .kick_o(link.kick_o), .kick_oe(link.kick_oe),
    .watchdog_kick_input(link.watchdog_kick_input),
    .watchdog_timeout_out_n(link.watchdog_timeout_out_n),
    .master_reset_in_n(link.master_reset_in_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic run(input int n);
    ntmo = 0;
    nrst = 0;
    step(n);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Bounds on time-out count over a quiet span, periods of TO to TO+7
  function automatic logic in_range(input int n, input int span);
    return n >= span / (TO + 7) && n <= span / TO + 1;
  endfunction
  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = $urandom(59);
    step(10);
    rst_n = 1'b1;
    run(80);
    chk(8'(ntmo), 8'h00);
    chk(8'(running), 8'h00);
    kick_en = 1'b1;
    run(40 + $urandom % 40);
    chk(8'(ntmo), 8'h00);
    chk(8'(running), 8'h01);
    chk(8'(kicking), 8'h01);
    kick_en = 1'b0;
    run(100);
    chk(8'(in_range(ntmo, 100)), 8'h01);
    chk(8'(nrst), 8'(ntmo));
    route = 1'b0;
    // Shortest master pulse first, then a random one; time-outs keep coming
    for (int k = 0; k < 2; k++)
    begin
      len = (k == 0) ? 1 : 2 + $urandom % 7;
      ntmo = 0;
      nrst = 0;
      mr_n = 1'b0;
      step(len);
      mr_n = 1'b1;
      step(60);
      chk(8'(nrst), 8'(len));
    end
    en_fit = 1'b0;
    kick_en = 1'b1;
    step(20);
    kick_en = 1'b0;
    run(80);
    chk(8'(ntmo), 8'h00);
    chk(8'(running), 8'h00);
    report_and_stop;
  end
  // Hang guard, several times the expected run
  initial
  begin
    #200us;
    mismatches++;
    report_and_stop;
  end
endmodule
